// File: logic/mis_consts.vh
// Constants for the interrupt sequencer: register offsets, fields, source and vector numbers, timing.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef MIS_CONSTS_VH
`define MIS_CONSTS_VH
`define MIS_OFF_PEND 8'h00
`define MIS_OFF_LVL0 8'h04
`define MIS_OFF_LVL1 8'h08
`define MIS_OFF_EXTCFG 8'h0c
`define MIS_OFF_KEYCFG 8'h10
`define MIS_OFF_MATCH0 8'h14
`define MIS_OFF_MATCH1 8'h18
`define MIS_OFF_MATCHEN 8'h1c
`define MIS_OFF_STATUS 8'h20
// Extcfg fields
`define MIS_EXT0_EN 0
`define MIS_EXT0_BOTH 1
`define MIS_EXT0_POL 2
`define MIS_EXT0_FLT 3
`define MIS_EXT1_POL 5
`define MIS_EXT2_POL 6
`define MIS_EXT3_SRC 7
`define MIS_EXT3_FLT 8
`define MIS_EXT3_HALF 10
// Source numbers on the peripheral request vector
`define MIS_SRC_KEY 4'd0
`define MIS_SRC_EXT0 4'd1
`define MIS_SRC_EXT1 4'd2
`define MIS_SRC_EXT2 4'd3
`define MIS_SRC_EXT3 4'd4
// Vector numbers
`define MIS_VEC_KEY 8'h0d
`define MIS_VEC_EXT0 8'h1d
`define MIS_VEC_EXT1 8'h19
`define MIS_VEC_EXT2 8'h15
`define MIS_VEC_EXT3 8'h1a
`define MIS_VEC_WDT 8'hf0
`define MIS_VEC_STEP 8'hf1
`define MIS_VEC_MATCH 8'hf2
`define MIS_SOFT_LO 8'h20
`define MIS_SOFT_HI 8'h3f
`define MIS_ENTRY_CYCLES 5'd20
`define MIS_LVL_NMI 4'h7
`define MIS_RING_DIV 7'h7f
`define MIS_FLG_I 6
`define MIS_FLG_D 5
`define MIS_FLG_U 7
`endif

// File: logic/mis_sequencer.v
// Interrupt acceptance and entry sequencer for a small CPU core, with pin request sources.
// Assumes pins asynchronous to clk_i, core signals synchronous, single clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "mis_consts.vh"
module mis_sequencer #(
  parameter NKEY = 4,
  parameter AW = 20
) (
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Pins
  input wire ext_input_0_i,
  input wire ext_input_1_i,
  input wire ext_input_2_i,
  input wire ext_input_3_i,
  input wire [NKEY-1:0] key_pin_i,
  input wire ring_clock_i,
  output reg ext0_port_level_o,
  output reg ext3_port_level_o,
  // Core side
  input wire instr_done_i,
  input wire instr_suspendable_i,
  input wire [AW-1:0] fetch_addr_i,
  input wire fetch_long_i,
  input wire [7:0] flag_register_i,
  input wire [3:0] processor_priority_level_i,
  input wire [AW-1:0] pc_i,
  input wire soft_req_i,
  input wire [7:0] soft_num_i,
  input wire wdt_req_i,
  input wire step_req_i,
  input wire return_from_interrupt_i,
  input wire [15:0] stack_data_i,
  input wire [AW-1:0] vector_i,
  output reg entry_busy_o,
  output reg [7:0] entry_num_o,
  output reg info_rd_o,
  output reg push_wr_o,
  output reg push_use_user_o,
  output reg [7:0] push_data_o,
  output reg [1:0] push_idx_o,
  output reg [7:0] flag_load_o,
  output reg flag_load_en_o,
  output reg [3:0] ipl_load_o,
  output reg ipl_load_en_o,
  output reg [AW-1:0] pc_load_o,
  output reg pc_load_en_o,
  output reg suspend_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SEQ = 2'd1;
  localparam ST_RET = 2'd2;

  // Two-stage synchronisers for every pin input
  wire [NKEY+4:0] pin_raw = {ring_clock_i, key_pin_i, ext_input_3_i, ext_input_2_i, ext_input_1_i, ext_input_0_i};
  reg [NKEY+4:0] sync1_reg;
  reg [NKEY+4:0] sync2_reg;
  reg [NKEY+4:0] prev_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= {(NKEY+5){1'b0}};
      sync2_reg <= {(NKEY+5){1'b0}};
      prev_reg <= {(NKEY+5){1'b0}};
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Software-visible configuration
  reg [4:0] pend_reg;
  reg [15:0] lvl_reg;
  reg [10:0] ext_cfg_reg;
  reg [2*NKEY-1:0] key_cfg_reg;
  reg [AW-1:0] match0_reg;
  reg [AW-1:0] match1_reg;
  reg [1:0] match_en_reg;

  // Filter sampling ticks: divide by 1, 8, 32 from the CPU clock
  reg [4:0] presc_reg;
  always @(posedge clk_i) begin
    if (rst_i)
      presc_reg <= 5'h00;
    else
      presc_reg <= presc_reg + 5'h01;
  end
  function tick_sel;
    input [1:0] sel;
    input [4:0] p;
    begin
      case (sel)
        2'b01: tick_sel = 1'b1;
        2'b10: tick_sel = (p[2:0] == 3'h0);
        2'b11: tick_sel = (p == 5'h00);
        default: tick_sel = 1'b0;
      endcase
    end
  endfunction

  // Three-agreement filters for inputs 0 and 3
  reg [2:0] f0_sh_reg;
  reg [2:0] f3_sh_reg;
  reg f0_reg;
  reg f3_reg;
  reg f0_prev_reg;
  reg f3_prev_reg;
  wire [1:0] f0_sel = ext_cfg_reg[`MIS_EXT0_FLT+1:`MIS_EXT0_FLT];
  wire [1:0] f3_sel = ext_cfg_reg[`MIS_EXT3_FLT+1:`MIS_EXT3_FLT];
  always @(posedge clk_i) begin
    if (rst_i) begin
      f0_sh_reg <= 3'h0;
      f3_sh_reg <= 3'h0;
      f0_reg <= 1'b0;
      f3_reg <= 1'b0;
      f0_prev_reg <= 1'b0;
      f3_prev_reg <= 1'b0;
    end else begin
      f0_prev_reg <= f0_reg;
      f3_prev_reg <= f3_reg;
      if (f0_sel == 2'b00)
        f0_reg <= sync2_reg[0];
      else if (tick_sel(f0_sel, presc_reg)) begin
        f0_sh_reg <= {f0_sh_reg[1:0], sync2_reg[0]};
        if (f0_sh_reg[1:0] == {2{sync2_reg[0]}})
          f0_reg <= sync2_reg[0];
      end
      if (f3_sel == 2'b00)
        f3_reg <= sync2_reg[3];
      else if (tick_sel(f3_sel, presc_reg)) begin
        f3_sh_reg <= {f3_sh_reg[1:0], sync2_reg[3]};
        if (f3_sh_reg[1:0] == {2{sync2_reg[3]}})
          f3_reg <= sync2_reg[3];
      end
    end
  end

  // Ring clock divide by 128, or by 64 with the half bit set
  reg [6:0] ring_cnt_reg;
  wire ring_edge = sync2_reg[NKEY+4] & ~prev_reg[NKEY+4];
  always @(posedge clk_i) begin
    if (rst_i)
      ring_cnt_reg <= 7'h00;
    else if (ring_edge)
      ring_cnt_reg <= ring_cnt_reg + 7'h01;
  end
  wire ring_ev = ring_edge && (ring_cnt_reg == `MIS_RING_DIV ||
    (ext_cfg_reg[`MIS_EXT3_HALF] && ring_cnt_reg == 7'h3f));

  // Edge events
  wire e0_rise = f0_reg & ~f0_prev_reg;
  wire e0_fall = ~f0_reg & f0_prev_reg;
  wire ev_ext0 = ext_cfg_reg[`MIS_EXT0_EN] && (ext_cfg_reg[`MIS_EXT0_BOTH] ? (e0_rise | e0_fall) :
    (ext_cfg_reg[`MIS_EXT0_POL] ? e0_rise : e0_fall));
  wire ev_ext1 = ext_cfg_reg[`MIS_EXT1_POL] ? (~sync2_reg[1] & prev_reg[1]) : (sync2_reg[1] & ~prev_reg[1]);
  wire ev_ext2 = ext_cfg_reg[`MIS_EXT2_POL] ? (~sync2_reg[2] & prev_reg[2]) : (sync2_reg[2] & ~prev_reg[2]);
  wire ev_ext3 = ext_cfg_reg[`MIS_EXT3_SRC] ? ring_ev : (f3_reg & ~f3_prev_reg) | (~f3_reg & f3_prev_reg & 1'b0) ;

  // Key pins: active level on an enabled pin masks the others
  wire [NKEY-1:0] key_act;
  wire [NKEY-1:0] key_edge;
  genvar gk;
  generate
    for (gk = 0; gk < NKEY; gk = gk + 1) begin : g_key
      wire edge_polarity = key_cfg_reg[NKEY+gk];
      assign key_act[gk] = key_cfg_reg[gk] && (sync2_reg[4+gk] == edge_polarity);
      assign key_edge[gk] = key_cfg_reg[gk] && (prev_reg[4+gk] != edge_polarity) && (sync2_reg[4+gk] == edge_polarity);
    end
  endgenerate
  wire key_blocked = |(key_act & ~key_edge & {NKEY{1'b1}}) ;
  wire ev_key = |key_edge && !key_blocked;

  // Request levels and acceptance
  wire [4:0] ev_vec = {ev_ext3, ev_ext2, ev_ext1, ev_ext0, ev_key};
  reg [7:0] flags_save_reg;
  reg [3:0] win_src_reg;
  reg [1:0] state_reg;
  reg [4:0] cnt_reg;
  reg [7:0] num_reg;
  reg [3:0] lvl_acc_reg;
  reg keep_ipl_reg;
  reg user_stack_reg;
  reg [AW-1:0] push_pc_reg;
  reg [AW-1:0] vec_reg;
  reg [1:0] ret_cnt_reg;
  reg [15:0] ret_hi_reg;

  // Fixed ranking among maskable sources: lower index wins on equal level
  reg [3:0] best_lvl;
  reg [3:0] best_src;
  reg best_ok;
  integer i;
  always @* begin
    best_lvl = 4'h0;
    best_src = 4'h0;
    best_ok = 1'b0;
    for (i = 4; i >= 0; i = i - 1) begin
      if (pend_reg[i] && {1'b0, lvl_reg[3*i +: 3]} > processor_priority_level_i &&
          {1'b0, lvl_reg[3*i +: 3]} >= best_lvl) begin
        best_lvl = {1'b0, lvl_reg[3*i +: 3]};
        best_src = i[3:0];
        best_ok = 1'b1;
      end
    end
    best_ok = best_ok & flag_register_i[`MIS_FLG_I];
  end
  wire match_hit0 = match_en_reg[0] && fetch_addr_i == match0_reg;
  wire match_hit1 = match_en_reg[1] && fetch_addr_i == match1_reg;
  wire match_hit = match_hit0 | match_hit1;
  wire boundary = instr_done_i | instr_suspendable_i;
  wire soft_now = soft_req_i;
  wire any_req = soft_now | wdt_req_i | best_ok | step_req_i | match_hit;
  wire start = (state_reg == ST_IDLE) && (soft_now || (boundary && any_req));

  // Bus decode
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire clr_acc = start && !soft_now && !wdt_req_i && best_ok;

  // Pending flags: hardware set beats software clear and acceptance clear
  always @(posedge clk_i) begin
    if (rst_i)
      pend_reg <= 5'h00;
    else begin
      if (wb_wr && wb_adr_i == `MIS_OFF_PEND)
        pend_reg <= (pend_reg & wb_dat_i[4:0]) | ev_vec;
      else if (clr_acc)
        pend_reg <= (pend_reg & ~(5'h01 << best_src)) | ev_vec;
      else
        pend_reg <= pend_reg | ev_vec;
    end
  end

  // Configuration registers and read back
  always @(posedge clk_i) begin
    if (rst_i) begin
      lvl_reg <= 16'h0000;
      ext_cfg_reg <= 11'h000;
      key_cfg_reg <= {(2*NKEY){1'b0}};
      match0_reg <= {AW{1'b0}};
      match1_reg <= {AW{1'b0}};
      match_en_reg <= 2'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_wr) begin
        case (wb_adr_i)
          `MIS_OFF_LVL0: lvl_reg <= wb_dat_i[15:0];
          `MIS_OFF_EXTCFG: ext_cfg_reg <= wb_dat_i[10:0];
          `MIS_OFF_KEYCFG: key_cfg_reg <= wb_dat_i[2*NKEY-1:0];
          `MIS_OFF_MATCH0: match0_reg <= wb_dat_i[AW-1:0];
          `MIS_OFF_MATCH1: match1_reg <= wb_dat_i[AW-1:0];
          `MIS_OFF_MATCHEN: match_en_reg <= wb_dat_i[1:0];
          default: ;
        endcase
      end
      case (wb_adr_i)
        `MIS_OFF_PEND: wb_dat_o <= {27'h0, pend_reg};
        `MIS_OFF_LVL0: wb_dat_o <= {16'h0, lvl_reg};
        `MIS_OFF_EXTCFG: wb_dat_o <= {21'h0, ext_cfg_reg};
        `MIS_OFF_KEYCFG: wb_dat_o <= {{(32-2*NKEY){1'b0}}, key_cfg_reg};
        `MIS_OFF_MATCH0: wb_dat_o <= {{(32-AW){1'b0}}, match0_reg};
        `MIS_OFF_MATCH1: wb_dat_o <= {{(32-AW){1'b0}}, match1_reg};
        `MIS_OFF_MATCHEN: wb_dat_o <= {30'h0, match_en_reg};
        `MIS_OFF_STATUS: wb_dat_o <= {16'h0, num_reg, 2'h0, state_reg, 1'b0, sync2_reg[3], f0_reg, entry_busy_o};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Vector number for the accepted maskable source
  reg [7:0] src_vec;
  always @* begin
    case (best_src)
      `MIS_SRC_KEY: src_vec = `MIS_VEC_KEY;
      `MIS_SRC_EXT0: src_vec = `MIS_VEC_EXT0;
      `MIS_SRC_EXT1: src_vec = `MIS_VEC_EXT1;
      `MIS_SRC_EXT2: src_vec = `MIS_VEC_EXT2;
      default: src_vec = `MIS_VEC_EXT3;
    endcase
  end

  // Entry and return sequencer; 20 cycles from start to handler
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
      num_reg <= 8'h00;
      lvl_acc_reg <= 4'h0;
      keep_ipl_reg <= 1'b0;
      user_stack_reg <= 1'b0;
      push_pc_reg <= {AW{1'b0}};
      flags_save_reg <= 8'h00;
      vec_reg <= {AW{1'b0}};
      ret_cnt_reg <= 2'h0;
      ret_hi_reg <= 16'h0000;
      entry_busy_o <= 1'b0;
      entry_num_o <= 8'h00;
      info_rd_o <= 1'b0;
      push_wr_o <= 1'b0;
      push_use_user_o <= 1'b0;
      push_data_o <= 8'h00;
      push_idx_o <= 2'h0;
      flag_load_o <= 8'h00;
      flag_load_en_o <= 1'b0;
      ipl_load_o <= 4'h0;
      ipl_load_en_o <= 1'b0;
      pc_load_o <= {AW{1'b0}};
      pc_load_en_o <= 1'b0;
      suspend_o <= 1'b0;
      ext0_port_level_o <= 1'b0;
      ext3_port_level_o <= 1'b0;
    end else begin
      ext0_port_level_o <= f0_reg;
      ext3_port_level_o <= sync2_reg[3];
      info_rd_o <= 1'b0;
      push_wr_o <= 1'b0;
      flag_load_en_o <= 1'b0;
      ipl_load_en_o <= 1'b0;
      pc_load_en_o <= 1'b0;
      suspend_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_SEQ;
            cnt_reg <= 5'h01;
            entry_busy_o <= 1'b1;
            info_rd_o <= 1'b1;
            suspend_o <= instr_suspendable_i & ~instr_done_i;
            flags_save_reg <= flag_register_i;
            push_pc_reg <= pc_i;
            keep_ipl_reg <= 1'b1;
            user_stack_reg <= 1'b0;
            lvl_acc_reg <= processor_priority_level_i;
            if (soft_now) begin
              num_reg <= soft_num_i;
              entry_num_o <= soft_num_i;
              user_stack_reg <= (soft_num_i >= `MIS_SOFT_LO && soft_num_i <= `MIS_SOFT_HI) &&
                flag_register_i[`MIS_FLG_U];
            end else if (wdt_req_i) begin
              num_reg <= `MIS_VEC_WDT;
              entry_num_o <= `MIS_VEC_WDT;
              lvl_acc_reg <= `MIS_LVL_NMI;
              keep_ipl_reg <= 1'b0;
            end else if (best_ok) begin
              num_reg <= src_vec;
              entry_num_o <= src_vec;
              lvl_acc_reg <= best_lvl;
              keep_ipl_reg <= 1'b0;
            end else if (step_req_i) begin
              num_reg <= `MIS_VEC_STEP;
              entry_num_o <= `MIS_VEC_STEP;
            end else begin
              num_reg <= `MIS_VEC_MATCH;
              entry_num_o <= `MIS_VEC_MATCH;
              push_pc_reg <= fetch_addr_i + {{(AW-2){1'b0}}, fetch_long_i, ~fetch_long_i};
            end
          end else if (return_from_interrupt_i) begin
            state_reg <= ST_RET;
            ret_cnt_reg <= 2'h0;
          end
        end
        ST_SEQ: begin
          cnt_reg <= cnt_reg + 5'h01;
          entry_num_o <= num_reg;
          vec_reg <= vector_i;
          if (cnt_reg == 5'h03) begin
            flag_load_o <= flags_save_reg & ~(8'h01 << `MIS_FLG_I) & ~(8'h01 << `MIS_FLG_D) &
              ~((num_reg >= `MIS_SOFT_LO && num_reg <= `MIS_SOFT_HI) ? 8'h00 : (8'h01 << `MIS_FLG_U));
            flag_load_en_o <= 1'b1;
          end
          if (cnt_reg >= 5'h08 && cnt_reg <= 5'h0b) begin
            push_wr_o <= 1'b1;
            push_use_user_o <= user_stack_reg;
            push_idx_o <= cnt_reg[1:0];
            case (cnt_reg[1:0])
              2'd0: push_data_o <= {lvl_acc_reg[3:0] & 4'h0 | processor_priority_level_i, push_pc_reg[AW-1:AW-4]};
              2'd1: push_data_o <= flags_save_reg;
              2'd2: push_data_o <= push_pc_reg[15:8];
              default: push_data_o <= push_pc_reg[7:0];
            endcase
          end
          if (cnt_reg == 5'h0e && !keep_ipl_reg) begin
            ipl_load_o <= lvl_acc_reg;
            ipl_load_en_o <= 1'b1;
          end
          if (cnt_reg == `MIS_ENTRY_CYCLES - 5'h01) begin
            pc_load_o <= vec_reg;
            pc_load_en_o <= 1'b1;
          end
          if (cnt_reg == `MIS_ENTRY_CYCLES) begin
            state_reg <= ST_IDLE;
            entry_busy_o <= 1'b0;
          end
        end
        ST_RET: begin
          ret_cnt_reg <= ret_cnt_reg + 2'h1;
          if (ret_cnt_reg == 2'h0)
            ret_hi_reg <= stack_data_i;
          if (ret_cnt_reg == 2'h1) begin
            flag_load_o <= ret_hi_reg[7:0];
            flag_load_en_o <= 1'b1;
            ipl_load_o <= ret_hi_reg[15:12];
            ipl_load_en_o <= 1'b1;
            pc_load_o <= {ret_hi_reg[11:8], stack_data_i};
            pc_load_en_o <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // mis_sequencer
`default_nettype wire

// File: tb/mis_sequencer_assertions.sv
// Checker for the interrupt sequencer: bus handshake, entry timing, pushes and loads.
// Assumes a bind to mis_sequencer; one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "mis_consts.vh"
module mis_seq_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic entry_busy_o,
  input wire logic [7:0] entry_num_o,
  input wire logic info_rd_o,
  input wire logic push_wr_o,
  input wire logic push_use_user_o,
  input wire logic [7:0] flag_register_i,
  input wire logic [7:0] flag_load_o,
  input wire logic flag_load_en_o,
  input wire logic [3:0] ipl_load_o,
  input wire logic ipl_load_en_o,
  input wire logic [3:0] processor_priority_level_i,
  input wire logic pc_load_en_o,
  input wire logic return_from_interrupt_i
);
  logic busy_q, soft_q, user_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Entry kind and stack flag taken on the first busy cycle, before flags change
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= entry_busy_o;
      if (entry_busy_o && !busy_q) begin
        soft_q <= (entry_num_o >= `MIS_SOFT_LO) && (entry_num_o <= `MIS_SOFT_HI);
        user_q <= flag_register_i[`MIS_FLG_U];
      end
    end
  end
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  entry_length_a: assert property ($rose(entry_busy_o) |-> ##19 pc_load_en_o ##1 !entry_busy_o)
    else $error("entry length wrong");
  info_first_a: assert property ($rose(entry_busy_o) |-> info_rd_o)
    else $error("info read missing");
  push_order_a: assert property ($rose(entry_busy_o) |-> ##8 push_wr_o [*4] ##1 !push_wr_o)
    else $error("push sequence wrong");
  flag_clear_a: assert property ($rose(entry_busy_o) |-> ##3 flag_load_en_o && !flag_load_o[`MIS_FLG_I]
    && !flag_load_o[`MIS_FLG_D] && flag_load_o[`MIS_FLG_U] == (soft_q && user_q)) else $error("flag clear wrong");
  stack_pick_a: assert property (push_wr_o |-> push_use_user_o == (soft_q && user_q))
    else $error("stack pointer choice wrong");
  ipl_wdt_a: assert property (entry_busy_o && ipl_load_en_o && entry_num_o == `MIS_VEC_WDT
    |-> ipl_load_o == `MIS_LVL_NMI) else $error("watchdog level wrong");
  ipl_soft_a: assert property (entry_busy_o && ipl_load_en_o && soft_q
    |-> ipl_load_o == processor_priority_level_i) else $error("soft level changed");
  return_load_a: assert property (return_from_interrupt_i |-> ##3 flag_load_en_o && pc_load_en_o)
    else $error("return loads missing");
  idle_quiet_a: assert property (!entry_busy_o |-> !push_wr_o && !info_rd_o)
    else $error("entry strobes while idle");
endmodule // mis_seq_chk
`default_nettype wire

// File: tb/mis_core_model.sv
// Behavioural core partner: instruction boundaries, flags, level, PC, stack bytes.
// Assumes the sequencer's core-side ports; pushes land in four byte slots.
`timescale 1ns/1ps
`default_nettype none
module mis_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic entry_busy_o,
  input wire logic [7:0] entry_num_o,
  input wire logic push_wr_o,
  input wire logic [7:0] push_data_o,
  input wire logic [7:0] flag_load_o,
  input wire logic flag_load_en_o,
  input wire logic [3:0] ipl_load_o,
  input wire logic ipl_load_en_o,
  input wire logic [19:0] pc_load_o,
  input wire logic pc_load_en_o,
  input wire logic return_from_interrupt_i,
  output logic instr_done_i,
  output logic [7:0] flag_register_i,
  output logic [3:0] processor_priority_level_i,
  output logic [19:0] pc_i,
  output logic [19:0] vector_i,
  output logic [15:0] stack_data_i
);
  logic [7:0] pb [0:3];
  logic [1:0] cnt, np;
  // Handler address follows the number, so a wrong vector shows in the PC
  assign vector_i = {12'h0c0, entry_num_o};
  // One instruction every four cycles, none while the entry runs
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 2'd0;
      np <= 2'd0;
      instr_done_i <= 1'b0;
      flag_register_i <= 8'h00;
      processor_priority_level_i <= 4'h0;
      pc_i <= 20'h5a3c6;
    end else begin
      cnt <= cnt + 2'd1;
      instr_done_i <= (cnt == 2'd3) && !entry_busy_o;
      if (flag_load_en_o) flag_register_i <= flag_load_o;
      if (ipl_load_en_o) processor_priority_level_i <= ipl_load_o;
      if (pc_load_en_o) pc_i <= pc_load_o;
      if (push_wr_o) begin
        pb[np] <= push_data_o;
        np <= np + 2'd1;
      end
      // Return hands over the flag word first, then the PC low word
      stack_data_i <= return_from_interrupt_i ? {pb[0], pb[1]} : {pb[2], pb[3]};
    end
  end
endmodule // mis_core_model
`default_nettype wire

// File: tb/tb_mis_sequencer.sv
// Testbench for the interrupt sequencer: register bus, soft, pin and watchdog entries, returns.
// Assumes mis_sequencer, the core model and the checker; 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "mis_consts.vh"
module tb_mis_sequencer;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic ext_input_0_i = 0, ext_input_1_i = 0, ext_input_2_i = 0, ext_input_3_i = 0, ring_clock_i = 0;
  logic [3:0] key_pin_i = 4'h0;
  logic ext0_port_level_o, ext3_port_level_o, instr_done_i, instr_suspendable_i = 0, fetch_long_i = 0;
  logic [19:0] pc_i, vector_i, pc_load_o;
  logic [7:0] flag_register_i, soft_num_i = 8'h00, entry_num_o, push_data_o, flag_load_o;
  logic [3:0] processor_priority_level_i, ipl_load_o;
  logic soft_req_i = 0, wdt_req_i = 0, step_req_i = 0, return_from_interrupt_i = 0;
  logic [15:0] stack_data_i;
  logic entry_busy_o, info_rd_o, push_wr_o, push_use_user_o, flag_load_en_o, ipl_load_en_o;
  logic pc_load_en_o, suspend_o;
  logic [1:0] push_idx_o;
  int bad_count = 0, samples_checked = 0, cyc_n = 0;
  always #4 clk_i = ~clk_i;
  mis_sequencer #(.NKEY(4), .AW(20)) mis_sequencer_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_input_0_i, .ext_input_1_i, .ext_input_2_i,
    .ext_input_3_i, .key_pin_i, .ring_clock_i, .ext0_port_level_o, .ext3_port_level_o, .instr_done_i,
    .instr_suspendable_i, .fetch_addr_i(pc_i), .fetch_long_i, .flag_register_i, .processor_priority_level_i,
    .pc_i, .soft_req_i, .soft_num_i, .wdt_req_i, .step_req_i, .return_from_interrupt_i, .stack_data_i,
    .vector_i, .entry_busy_o, .entry_num_o, .info_rd_o, .push_wr_o, .push_use_user_o, .push_data_o,
    .push_idx_o, .flag_load_o, .flag_load_en_o, .ipl_load_o, .ipl_load_en_o, .pc_load_o, .pc_load_en_o,
    .suspend_o);
  mis_core_model mis_core_model_i (.clk_i, .rst_i, .entry_busy_o, .entry_num_o, .push_wr_o, .push_data_o,
    .flag_load_o, .flag_load_en_o, .ipl_load_o, .ipl_load_en_o, .pc_load_o, .pc_load_en_o,
    .return_from_interrupt_i, .instr_done_i, .flag_register_i, .processor_priority_level_i, .pc_i,
    .vector_i, .stack_data_i);
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then drop for one cycle
  task wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Waits for an entry, checks its number, then lets it finish
  task entry(input logic [7:0] num);
    int n;
    n = 0;
    while (entry_busy_o !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    check(entry_num_o, num, "entry number");
    while (entry_busy_o !== 1'b0) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
  endtask
  task core(input logic [7:0] f, input logic [3:0] l);
    mis_core_model_i.flag_register_i <= f;
    mis_core_model_i.processor_priority_level_i <= l;
    @(posedge clk_i);
  endtask
  task ret;
    return_from_interrupt_i <= 1'b1;
    @(posedge clk_i);
    return_from_interrupt_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task ext0_edge;
    ext_input_0_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    ext_input_0_i <= 1'b1;
    repeat (12) @(posedge clk_i);
  endtask
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(entry_busy_o, 1'b0, "busy after reset");
    wbx(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0, "unmapped read");
    // Software entry with user stack selected keeps the level and the U flag
    core(8'hc0, 4'h2);
    soft_num_i <= 8'h21;
    soft_req_i <= 1'b1;
    @(posedge clk_i);
    soft_req_i <= 1'b0;
    entry(8'h21);
    check({mis_core_model_i.pb[0], mis_core_model_i.pb[1], mis_core_model_i.pb[2], mis_core_model_i.pb[3]},
      {4'h2, 4'h5, 8'hc0, 8'ha3, 8'hc6}, "pushed bytes");
    check(pc_i, 20'h0c021, "handler pc");
    check(processor_priority_level_i, 4'h2, "soft level");
    check(flag_register_i, 8'h80, "flags in handler");
    ret;
    check({flag_register_i, processor_priority_level_i, pc_i}, {8'hc0, 4'h2, 20'h5a3c6}, "after return");
    // Input 0 disabled: an edge leaves nothing pending
    wbx(1'b1, `MIS_OFF_LVL0, 32'h18);
    ext0_edge;
    wbx(1'b0, `MIS_OFF_PEND, 32'h0);
    check(rd[1], 1'b0, "disabled input 0");
    ext_input_0_i <= 1'b0;
    // Enabled, rising edge, level 3 against priority 3: pending but refused
    core(8'h40, 4'h3);
    wbx(1'b1, `MIS_OFF_EXTCFG, 32'h5);
    ext0_edge;
    repeat (40) @(posedge clk_i);
    check(entry_busy_o, 1'b0, "level not above priority");
    wbx(1'b0, `MIS_OFF_PEND, 32'h0);
    check(rd[1], 1'b1, "input 0 pending");
    core(8'h40, 4'h0);
    entry(`MIS_VEC_EXT0);
    check(processor_priority_level_i, 4'h3, "accepted level");
    wbx(1'b0, `MIS_OFF_PEND, 32'h0);
    check(rd[1], 1'b0, "pending cleared on entry");
    ret;
    // Watchdog ignores the I flag and raises the level to 7; dropped once running to avoid a re-entry
    core(8'h00, 4'h0);
    wdt_req_i <= 1'b1;
    ext0_edge;
    wdt_req_i <= 1'b0;
    entry(`MIS_VEC_WDT);
    check(processor_priority_level_i, 4'h7, "watchdog level");
    ret;
    // Software clear of the still pending input 0
    core(8'h00, 4'h0);
    wbx(1'b0, `MIS_OFF_PEND, 32'h0);
    check(rd[1], 1'b1, "pending with I clear");
    wbx(1'b1, `MIS_OFF_PEND, 32'h0);
    wbx(1'b0, `MIS_OFF_PEND, 32'h0);
    check(rd[1], 1'b0, "software clear");
    complete_run;
  end
endmodule // tb_mis_sequencer
bind mis_sequencer mis_seq_chk mis_seq_chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .entry_busy_o,
  .entry_num_o, .info_rd_o, .push_wr_o, .push_use_user_o, .flag_register_i, .flag_load_o, .flag_load_en_o,
  .ipl_load_o, .ipl_load_en_o, .processor_priority_level_i, .pc_load_en_o, .return_from_interrupt_i);
`default_nettype wire
